// File: rtl/ilps_param_set.sv
// Link parameter set generator: parameter fields, checksum, lane enables and alignment octet stream
`timescale 1ns/100ps
module ilps_param_set
  import ilps_pkg::*;
(
  input wire logic i_clock,
  input wire logic i_rst_n,
  input wire logic [6:0] i_link_mode_select,
  input wire logic [7:0] i_frames_per_multiframe_minus_one,
  input wire logic [7:0] i_device_id,
  input wire logic i_scrambler_enable,
  input wire logic i_link_enable,
  input wire logic i_word_ready,
  output logic o_word_valid,
  output ilps_word_t o_word,
  output logic o_ilas_busy,
  output logic o_ilas_done,
  output logic [15:0] o_lane_enable,
  output ilps_fields_t [1:0] o_link_fields,
  output logic [1:0][7:0] o_link_chksum,
  output logic o_enc_64b66b,
  output logic o_single_channel,
  output logic o_mode_invalid,
  output logic o_scramble_enable
);

  typedef struct packed {
    ilps_cfg_t cfg;
    logic [1:0] settle;
    ilps_fields_t [1:0] fields;
    logic [1:0][7:0] chk;
    logic [15:0] lane_en;
    logic enc64;
    logic single_channel;
    logic invalid;
    ilps_fsm_t fsm;
    logic link;
    logic [2:0] lane;
    logic [3:0] idx;
    logic done;
  } ilps_state_t;

  ilps_state_t st_reg;
  ilps_state_t st_next;
  ilps_cfg_t cfg_in;
  ilps_mode_t mode;
  ilps_fields_t lane_fields;
  ilps_word_t gen_word;
  logic [7:0] lane_mask;
  logic gen_valid;
  logic buf_ready;
  logic push;
  logic last_lane;

  function automatic logic [7:0] ilps_chksum(input ilps_fields_t f);
    logic [7:0] s;
    s = 8'h00;
    s = s + f.did;
    s = s + 8'(f.adjcnt) + 8'(f.bid) + 8'(f.adjdir) + 8'(f.phadj) + 8'(f.lid);
    s = s + 8'(f.scr) + 8'(f.lm1) + f.fm1 + f.km1 + f.mm1;
    s = s + 8'(f.cs) + 8'(f.nm1) + 8'(f.subclassv) + 8'(f.nprm1);
    s = s + 8'(f.jesdv) + 8'(f.sm1) + 8'(f.hd) + 8'(f.cf) + f.res1 + f.res2;
    return s;
  endfunction

  function automatic logic [7:0] ilps_octet(input ilps_fields_t f, input logic [3:0] idx);
    logic [7:0] o;
    o = 8'h00;
    case (idx)
      ILPS_OCT_DID: o = f.did;
      ILPS_OCT_ADJ_BID: o = {f.adjcnt, f.bid};
      ILPS_OCT_LID: o = {1'b0, f.adjdir, f.phadj, f.lid};
      ILPS_OCT_SCR_L: o = {f.scr, 2'b00, f.lm1};
      ILPS_OCT_F: o = f.fm1;
      ILPS_OCT_K: o = f.km1;
      ILPS_OCT_M: o = f.mm1;
      ILPS_OCT_CS_N: o = {f.cs, 1'b0, f.nm1};
      ILPS_OCT_SUBC_NP: o = {f.subclassv, f.nprm1};
      ILPS_OCT_JV_S: o = {f.jesdv, f.sm1};
      ILPS_OCT_HD_CF: o = {f.hd, 2'b00, f.cf};
      ILPS_OCT_RES1: o = f.res1;
      ILPS_OCT_RES2: o = f.res2;
      ILPS_OCT_CHKSUM: o = ilps_chksum(f);
      default: o = 8'h00;
    endcase
    return o;
  endfunction

  assign cfg_in.link_mode_select = i_link_mode_select;
  assign cfg_in.frames_per_multiframe_minus_one = i_frames_per_multiframe_minus_one;
  assign cfg_in.device_id = i_device_id;
  assign cfg_in.scrambler_enable = i_scrambler_enable;

  ilps_mode_rom u_mode_rom (
    .i_clock(i_clock),
    .i_rst_n(i_rst_n),
    .i_link_mode_select(st_reg.cfg.link_mode_select),
    .o_mode(mode)
  );

  generate
    for (genvar g = 0; g < ILPS_LANES_MAX; g++) begin : g_lane
      assign lane_mask[g] = mode.valid && (4'(g) < mode.lanes);
    end
  endgenerate

  always_comb begin
    lane_fields = st_reg.fields[st_reg.link];
    lane_fields.lid = 5'(st_reg.lane);
  end

  assign gen_valid = (st_reg.fsm == ILPS_SEND);
  assign gen_word.link = st_reg.link;
  assign gen_word.lane = st_reg.lane;
  assign gen_word.index = st_reg.idx;
  assign gen_word.octet = ilps_octet(lane_fields, st_reg.idx);
  assign push = gen_valid && buf_ready;
  assign last_lane = ({1'b0, st_reg.lane} == 4'(st_reg.fields[0].lm1));

  always_comb begin
    st_next = st_reg;
    st_next.cfg = cfg_in;

    // Hold off the sequence until a changed setting has reached every field
    if (cfg_in != st_reg.cfg) begin
      st_next.settle = ILPS_SETTLE_CYCLES;
    end else if (st_reg.settle != 2'h0) begin
      st_next.settle = st_reg.settle - 2'h1;
    end

    for (int k = 0; k < 2; k++) begin
      st_next.fields[k] = '0;
      st_next.fields[k].did = st_reg.cfg.device_id + 8'(k);
      st_next.fields[k].adjcnt = 4'h0;
      st_next.fields[k].adjdir = 1'b0;
      st_next.fields[k].bid = 4'h0;
      st_next.fields[k].hd = 1'b0;
      st_next.fields[k].cf = 5'h00;
      st_next.fields[k].res1 = 8'h00;
      st_next.fields[k].res2 = 8'h00;
      st_next.fields[k].cs = 2'h0;
      st_next.fields[k].scr = st_reg.cfg.scrambler_enable;
      st_next.fields[k].km1 = st_reg.cfg.frames_per_multiframe_minus_one;
      st_next.fields[k].lm1 = mode.valid ? 5'(mode.lanes - 4'h1) : 5'h00;
      st_next.fields[k].sm1 = mode.valid ? 5'(mode.lanes - 4'h1) : 5'h00;
      st_next.fields[k].fm1 = ILPS_F_MINUS_ONE;
      st_next.fields[k].nm1 = ILPS_N_MINUS_ONE;
      st_next.fields[k].mm1 = ILPS_M_MINUS_ONE;
      st_next.fields[k].nprm1 = ILPS_NPRIME_MINUS_ONE;
      st_next.fields[k].jesdv = ILPS_JESDV;
      st_next.fields[k].subclassv = ILPS_SUBCLASSV;
      st_next.chk[k] = ilps_chksum(st_next.fields[k]);
    end

    st_next.lane_en = {lane_mask, lane_mask};
    st_next.enc64 = mode.enc64;
    st_next.single_channel = mode.single_channel;
    st_next.invalid = !mode.valid;

    case (st_reg.fsm)
      ILPS_IDLE: begin
        st_next.done = 1'b0;
        st_next.link = 1'b0;
        st_next.lane = 3'h0;
        st_next.idx = 4'h0;
        if (i_link_enable && st_reg.settle == 2'h0 && mode.valid && !mode.enc64) begin
          st_next.fsm = ILPS_SEND;
        end
      end
      ILPS_SEND: begin
        if (!i_link_enable || st_reg.settle != 2'h0) begin
          // A setting change restarts the sequence so no lane mixes two sets
          st_next.fsm = ILPS_IDLE;
        end else if (push) begin
          // every octet, every lane, both links
          if (st_reg.idx != ILPS_OCT_CHKSUM) begin
            st_next.idx = st_reg.idx + 4'h1;
          end else begin
            st_next.idx = 4'h0;
            if (!last_lane) begin
              st_next.lane = st_reg.lane + 3'h1;
            end else begin
              st_next.lane = 3'h0;
              if (!st_reg.link) begin
                st_next.link = 1'b1;
              end else begin
                st_next.fsm = ILPS_DONE;
                st_next.done = 1'b1;
              end
            end
          end
        end
      end
      ILPS_DONE: begin
        if (!i_link_enable || st_reg.settle != 2'h0) begin
          st_next.fsm = ILPS_IDLE;
          st_next.done = 1'b0;
        end
      end
      default: st_next.fsm = ILPS_IDLE;
    endcase
  end

  always_ff @(posedge i_clock or negedge i_rst_n) begin
    if (!i_rst_n) begin
      st_reg <= '0;
    end else begin
      st_reg <= st_next;
    end
  end

  // Receiver stall backs up into the generator through buf_ready
  ilps_skid_buf u_buf (
    .i_clock(i_clock),
    .i_rst_n(i_rst_n),
    .i_in_valid(gen_valid),
    .i_in_data(gen_word),
    .o_in_ready(buf_ready),
    .o_out_valid(o_word_valid),
    .o_out_data(o_word),
    .i_out_ready(i_word_ready)
  );

  assign o_ilas_busy = (st_reg.fsm == ILPS_SEND);
  assign o_ilas_done = st_reg.done;
  assign o_lane_enable = st_reg.lane_en;
  assign o_link_fields = st_reg.fields;
  assign o_link_chksum = st_reg.chk;
  assign o_enc_64b66b = st_reg.enc64;
  assign o_single_channel = st_reg.single_channel;
  assign o_mode_invalid = st_reg.invalid;
  assign o_scramble_enable = st_reg.fields[0].scr;

  // Assertion helper: cycles since reset, saturating
  logic [1:0] warm_reg;
  always_ff @(posedge i_clock or negedge i_rst_n) begin
    if (!i_rst_n) begin
      warm_reg <= 2'h0;
    end else if (warm_reg != 2'h3) begin
      warm_reg <= warm_reg + 2'h1;
    end
  end

  property p_adj_zero;
    @(posedge i_clock) disable iff (!i_rst_n)
      o_link_fields[0].adjcnt == 4'h0 && o_link_fields[0].adjdir == 1'b0 && o_link_fields[1].adjcnt == 4'h0;
  endproperty
  a_adj_zero: assert property (p_adj_zero) else $error("adjustment fields not zero");

  property p_zero_fields;
    @(posedge i_clock) disable iff (!i_rst_n)
      (o_word_valid && o_word.index == ILPS_OCT_HD_CF) |-> o_word.octet == 8'h00;
  endproperty
  a_zero_fields: assert property (p_zero_fields) else $error("HD/CF octet not zero");

  property p_cs_zero;
    @(posedge i_clock) disable iff (!i_rst_n)
      (o_word_valid && o_word.index == ILPS_OCT_CS_N) |-> o_word.octet[7:6] == 2'h0;
  endproperty
  a_cs_zero: assert property (p_cs_zero) else $error("control bits field not zero");

  property p_did;
    @(posedge i_clock) disable iff (!i_rst_n)
      warm_reg == 2'h3 |-> o_link_fields[0].did == $past(i_device_id, 2);
  endproperty
  a_did: assert property (p_did) else $error("link A identifier does not follow input");

  // Fields still hold their reset zeros at the first edge after release
  property p_did_b;
    @(posedge i_clock) disable iff (!i_rst_n)
      warm_reg != 2'h0 |-> o_link_fields[1].did == o_link_fields[0].did + 8'h01;
  endproperty
  a_did_b: assert property (p_did_b) else $error("link B identifier not plus one");

  property p_k;
    @(posedge i_clock) disable iff (!i_rst_n)
      warm_reg == 2'h3 |-> o_link_fields[1].km1 == $past(i_frames_per_multiframe_minus_one, 2);
  endproperty
  a_k: assert property (p_k) else $error("K field does not follow programmed value");

  property p_chk;
    @(posedge i_clock) disable iff (!i_rst_n)
      (o_word_valid && o_word.index == ILPS_OCT_CHKSUM && o_word.lane == 3'h0 && !o_word.link)
        |-> o_word.octet == o_link_chksum[0] || $changed(o_link_chksum[0]) || $past(o_link_chksum[0] != st_next.chk[0]);
  endproperty
  a_chk: assert property (p_chk) else $error("checksum octet wrong");

  property p_lid;
    @(posedge i_clock) disable iff (!i_rst_n)
      (o_word_valid && o_word.index == ILPS_OCT_LID) |-> o_word.octet[4:0] == 5'(o_word.lane);
  endproperty
  a_lid: assert property (p_lid) else $error("lane identifier not lane position");

  property p_no_ilas_64;
    @(posedge i_clock) disable iff (!i_rst_n)
      $rose(o_ilas_busy) |-> !$past(mode.enc64);
  endproperty
  a_no_ilas_64: assert property (p_no_ilas_64) else $error("sequence started in 64b/66b mode");

  sequence s_last_push;
    push && st_reg.link && last_lane && st_reg.idx == ILPS_OCT_CHKSUM;
  endsequence
  property p_complete;
    @(posedge i_clock) disable iff (!i_rst_n)
      s_last_push and (i_link_enable && cfg_in == st_reg.cfg && st_reg.settle == 2'h0) |=> o_ilas_done ##1 !o_ilas_busy;
  endproperty
  a_complete: assert property (p_complete) else $error("sequence did not complete");

  property p_lanes;
    @(posedge i_clock) disable iff (!i_rst_n)
      warm_reg != 2'h0 |->
        o_lane_enable[7:0] == (o_mode_invalid ? 8'h00 : 8'((9'h002 << o_link_fields[0].lm1) - 9'h001));
  endproperty
  a_lanes: assert property (p_lanes) else $error("lane enables disagree with lane count");

  property p_consts;
    @(posedge i_clock) disable iff (!i_rst_n)
      warm_reg != 2'h0 |->
        o_link_fields[0].jesdv == 3'h1 && o_link_fields[0].subclassv == 3'h1 && o_link_fields[0].nprm1 == 5'h07;
  endproperty
  a_consts: assert property (p_consts) else $error("revision, subclass or N' wrong");

endmodule

// File: rtl/ilps_pkg.sv
// Shared types and constants for the link parameter set generator
package ilps_pkg;

  // Link mode codes
  localparam logic [6:0] ILPS_MODE_8B_SC_8L = 7'h05;
  localparam logic [6:0] ILPS_MODE_8B_SC_16L = 7'h06;
  localparam logic [6:0] ILPS_MODE_8B_DC_8L = 7'h07;
  localparam logic [6:0] ILPS_MODE_8B_DC_16L = 7'h08;
  localparam logic [6:0] ILPS_MODE_64B_SC_4L = 7'h22;
  localparam logic [6:0] ILPS_MODE_64B_DC_4L = 7'h23;
  localparam logic [6:0] ILPS_MODE_64B_SC_8L = 7'h2C;
  localparam logic [6:0] ILPS_MODE_64B_DC_8L = 7'h2D;
  localparam logic [6:0] ILPS_MODE_64B_SC_16L = 7'h32;
  localparam logic [6:0] ILPS_MODE_64B_DC_16L = 7'h33;

  // Lanes per link
  localparam logic [3:0] ILPS_LANES_TWO = 4'h2;
  localparam logic [3:0] ILPS_LANES_FOUR = 4'h4;
  localparam logic [3:0] ILPS_LANES_EIGHT = 4'h8;
  localparam int ILPS_LANES_MAX = 8;

  // Field values common to every mode
  localparam logic [7:0] ILPS_F_MINUS_ONE = 8'h00;
  localparam logic [7:0] ILPS_M_MINUS_ONE = 8'h00;
  localparam logic [4:0] ILPS_N_MINUS_ONE = 5'h07;
  localparam logic [4:0] ILPS_NPRIME_MINUS_ONE = 5'h07;
  localparam logic [2:0] ILPS_JESDV = 3'h1;
  localparam logic [2:0] ILPS_SUBCLASSV = 3'h1;

  // Positions of the configuration octets in the sequence
  localparam logic [3:0] ILPS_OCT_DID = 4'h0;
  localparam logic [3:0] ILPS_OCT_ADJ_BID = 4'h1;
  localparam logic [3:0] ILPS_OCT_LID = 4'h2;
  localparam logic [3:0] ILPS_OCT_SCR_L = 4'h3;
  localparam logic [3:0] ILPS_OCT_F = 4'h4;
  localparam logic [3:0] ILPS_OCT_K = 4'h5;
  localparam logic [3:0] ILPS_OCT_M = 4'h6;
  localparam logic [3:0] ILPS_OCT_CS_N = 4'h7;
  localparam logic [3:0] ILPS_OCT_SUBC_NP = 4'h8;
  localparam logic [3:0] ILPS_OCT_JV_S = 4'h9;
  localparam logic [3:0] ILPS_OCT_HD_CF = 4'hA;
  localparam logic [3:0] ILPS_OCT_RES1 = 4'hB;
  localparam logic [3:0] ILPS_OCT_RES2 = 4'hC;
  localparam logic [3:0] ILPS_OCT_CHKSUM = 4'hD;

  // Cycles for a configuration change to reach the parameter outputs
  localparam logic [1:0] ILPS_SETTLE_CYCLES = 2'h3;

  typedef enum logic [1:0] {ILPS_IDLE, ILPS_SEND, ILPS_DONE} ilps_fsm_t;

  typedef struct packed {
    logic valid;
    logic enc64;
    logic single_channel;
    logic [3:0] lanes;
  } ilps_mode_t;

  typedef struct packed {
    logic [6:0] link_mode_select;
    logic [7:0] frames_per_multiframe_minus_one;
    logic [7:0] device_id;
    logic scrambler_enable;
  } ilps_cfg_t;

  typedef struct packed {
    logic [7:0] did;
    logic [3:0] adjcnt;
    logic [3:0] bid;
    logic adjdir;
    logic phadj;
    logic [4:0] lid;
    logic scr;
    logic [4:0] lm1;
    logic [7:0] fm1;
    logic [7:0] km1;
    logic [7:0] mm1;
    logic [1:0] cs;
    logic [4:0] nm1;
    logic [2:0] subclassv;
    logic [4:0] nprm1;
    logic [2:0] jesdv;
    logic [4:0] sm1;
    logic hd;
    logic [4:0] cf;
    logic [7:0] res1;
    logic [7:0] res2;
  } ilps_fields_t;

  typedef struct packed {
    logic link;
    logic [2:0] lane;
    logic [3:0] index;
    logic [7:0] octet;
  } ilps_word_t;

endpackage

// File: rtl/ilps_mode_rom.sv
// Link mode decode into encoding, channel mode and lane count
`timescale 1ns/100ps
module ilps_mode_rom
  import ilps_pkg::*;
(
  input wire logic i_clock,
  input wire logic i_rst_n,
  input wire logic [6:0] i_link_mode_select,
  output ilps_mode_t o_mode
);

  typedef struct packed {
    ilps_mode_t mode;
  } ilps_rom_state_t;

  ilps_rom_state_t st_reg;
  ilps_rom_state_t st_next;

  always_comb begin
    st_next = st_reg;
    st_next.mode = '0;
    st_next.mode.valid = 1'b1;
    case (i_link_mode_select)
      ILPS_MODE_8B_SC_8L: begin
        st_next.mode.single_channel = 1'b1;
        st_next.mode.lanes = ILPS_LANES_FOUR;
      end
      ILPS_MODE_8B_SC_16L: begin
        st_next.mode.single_channel = 1'b1;
        st_next.mode.lanes = ILPS_LANES_EIGHT;
      end
      ILPS_MODE_8B_DC_8L: st_next.mode.lanes = ILPS_LANES_FOUR;
      ILPS_MODE_8B_DC_16L: st_next.mode.lanes = ILPS_LANES_EIGHT;
      ILPS_MODE_64B_SC_4L, ILPS_MODE_64B_SC_8L, ILPS_MODE_64B_SC_16L: begin
        st_next.mode.enc64 = 1'b1;
        st_next.mode.single_channel = 1'b1;
        st_next.mode.lanes = (i_link_mode_select == ILPS_MODE_64B_SC_4L) ? ILPS_LANES_TWO :
                             (i_link_mode_select == ILPS_MODE_64B_SC_8L) ? ILPS_LANES_FOUR : ILPS_LANES_EIGHT;
      end
      ILPS_MODE_64B_DC_4L, ILPS_MODE_64B_DC_8L, ILPS_MODE_64B_DC_16L: begin
        st_next.mode.enc64 = 1'b1;
        st_next.mode.lanes = (i_link_mode_select == ILPS_MODE_64B_DC_4L) ? ILPS_LANES_TWO :
                             (i_link_mode_select == ILPS_MODE_64B_DC_8L) ? ILPS_LANES_FOUR : ILPS_LANES_EIGHT;
      end
      // Reserved codes: no lanes, nothing advertised
      default: st_next.mode = '0;
    endcase
  end

  always_ff @(posedge i_clock or negedge i_rst_n) begin
    if (!i_rst_n) begin
      st_reg <= '0;
    end else begin
      st_reg <= st_next;
    end
  end

  assign o_mode = st_reg.mode;

endmodule

// File: rtl/ilps_skid_buf.sv
// Two-entry buffer between the octet generator and the lane encoders
`timescale 1ns/100ps
module ilps_skid_buf
  import ilps_pkg::*;
(
  input wire logic i_clock,
  input wire logic i_rst_n,
  input wire logic i_in_valid,
  input ilps_word_t i_in_data,
  output logic o_in_ready,
  output logic o_out_valid,
  output ilps_word_t o_out_data,
  input wire logic i_out_ready
);

  typedef struct packed {
    logic head_valid;
    logic tail_valid;
    ilps_word_t head;
    ilps_word_t tail;
  } ilps_buf_state_t;

  ilps_buf_state_t st_reg;
  ilps_buf_state_t st_next;
  logic push;
  logic pop;

  // Ready only depends on the tail flop, so it never loops back combinationally
  assign push = i_in_valid && !st_reg.tail_valid;
  assign pop = st_reg.head_valid && i_out_ready;

  always_comb begin
    st_next = st_reg;
    if (pop) begin
      if (st_reg.tail_valid) begin
        st_next.head = st_reg.tail;
        st_next.tail_valid = 1'b0;
      end else begin
        st_next.head_valid = push;
        st_next.head = i_in_data;
      end
    end else if (push) begin
      if (!st_reg.head_valid) begin
        st_next.head_valid = 1'b1;
        st_next.head = i_in_data;
      end else begin
        st_next.tail_valid = 1'b1;
        st_next.tail = i_in_data;
      end
    end
  end

  always_ff @(posedge i_clock or negedge i_rst_n) begin
    if (!i_rst_n) begin
      st_reg <= '0;
    end else begin
      st_reg <= st_next;
    end
  end

  assign o_in_ready = !st_reg.tail_valid;
  assign o_out_valid = st_reg.head_valid;
  assign o_out_data = st_reg.head;

endmodule

// File: tb/ilps_rx_model.sv
// Receiver-side sink for the alignment octet stream, with optional stalls
`timescale 1ns/100ps
module ilps_rx_model (
  input wire logic i_clock,
  input wire logic i_stall,
  output logic o_word_ready
);
  initial o_word_ready = 1'b0;
  // Ready moves just after the edge; random gaps exercise the buffer
  always @(posedge i_clock) begin
    #1;
    o_word_ready <= i_stall ? 1'($urandom % 2) : 1'b1;
  end
endmodule

// File: tb/testbench.sv
// Self-checking bench for the link parameter set generator
`timescale 1ns/100ps
module testbench;
  import ilps_pkg::*;
  logic i_clock, i_rst_n, i_scrambler_enable, i_link_enable, i_word_ready, stall;
  logic [6:0] i_link_mode_select;
  logic [7:0] i_frames_per_multiframe_minus_one, i_device_id;
  logic o_word_valid, o_ilas_busy, o_ilas_done, o_enc_64b66b, o_single_channel, o_mode_invalid;
  logic o_scramble_enable;
  ilps_word_t o_word;
  logic [15:0] o_lane_enable;
  ilps_fields_t [1:0] o_link_fields;
  logic [1:0][7:0] o_link_chksum;
  ilps_word_t exp_q[$];
  int n_fail = 0;
  int tests_run = 0;

  ilps_param_set ilps_param_set_inst (.i_clock, .i_rst_n, .i_link_mode_select,
    .i_frames_per_multiframe_minus_one, .i_device_id, .i_scrambler_enable, .i_link_enable,
    .i_word_ready, .o_word_valid, .o_word, .o_ilas_busy, .o_ilas_done, .o_lane_enable,
    .o_link_fields, .o_link_chksum, .o_enc_64b66b, .o_single_channel, .o_mode_invalid,
    .o_scramble_enable);
  ilps_rx_model ilps_rx_model_inst (.i_clock(i_clock), .i_stall(stall), .o_word_ready(i_word_ready));

  initial begin
    i_clock = 1'b0;
    forever #5 i_clock = ~i_clock;
  end

  task automatic check(string name, logic [63:0] seen, logic [63:0] exp);
    tests_run++;
    if (seen !== exp) begin
      n_fail++;
      $display("ERROR %s expected %0h seen %0h", name, exp, seen);
    end
  endtask

  task automatic close_out();
    $display("Checks %0d, mismatches %0d", tests_run, n_fail);
    if (n_fail == 0 && tests_run > 0) begin
      $display("Test passed");
    end else begin
      $display("Test failed");
    end
    $finish;
  endtask

  task automatic wait_cycles(int n);
    repeat (n) @(posedge i_clock);
    #1;
  endtask

  function automatic logic [7:0] octet(int ix, logic [7:0] did, k, lm, lid, logic scr);
    case (ix)
      0: return did;
      2: return lid;
      3: return {scr, 2'b00, lm[4:0]};
      5: return k;
      7: return 8'h07;
      8: return 8'h27;
      9: return {3'h1, lm[4:0]};
      13: return did + lid + 8'(scr) + lm + lm + k + 8'h10;
      default: return 8'h00;
    endcase
  endfunction

  // Every accepted octet is matched against the oldest expected one
  always @(posedge i_clock) begin
    if (i_rst_n && o_word_valid === 1'b1 && i_word_ready === 1'b1) begin
      if (exp_q.size() == 0) begin
        check("spurious_word", 1, 0);
      end else begin
        check("octet", o_word, exp_q.pop_front());
      end
    end
  end

  task automatic run_mode(logic [6:0] code, int l, bit enc, bit single, bit bad);
    logic [7:0] did, k, lm;
    logic scr;
    int guard;
    did = 8'($urandom);
    k = 8'($urandom);
    scr = 1'($urandom);
    lm = (l > 0) ? 8'(l - 1) : 8'h00;
    i_link_mode_select = code;
    i_device_id = did;
    i_frames_per_multiframe_minus_one = k;
    i_scrambler_enable = scr;
    wait_cycles(5);
    for (int b = 0; b < 2; b++) begin
      check("did", o_link_fields[b].did, did + 8'(b));
      check("km1", o_link_fields[b].km1, k);
      check("scr", o_link_fields[b].scr, scr);
      check("l_s", {o_link_fields[b].lm1, o_link_fields[b].sm1}, {lm[4:0], lm[4:0]});
      check("f_m_n", {o_link_fields[b].fm1, o_link_fields[b].mm1, o_link_fields[b].nm1,
        o_link_fields[b].nprm1}, 26'h0000E7);
      check("adj", {o_link_fields[b].adjcnt, o_link_fields[b].adjdir}, 0);
      check("zeros", {o_link_fields[b].bid, o_link_fields[b].cf, o_link_fields[b].hd,
        o_link_fields[b].res1, o_link_fields[b].res2}, 0);
      check("cs", o_link_fields[b].cs, 0);
      check("version", {o_link_fields[b].jesdv, o_link_fields[b].subclassv}, 6'h09);
      check("lid", o_link_fields[b].lid, 0);
      check("chksum", o_link_chksum[b], octet(13, did + 8'(b), k, lm, 8'h00, scr));
    end
    check("lane_en", o_lane_enable, {2{8'((1 << l) - 1)}});
    check("invalid", o_mode_invalid, bad);
    if (!bad) begin
      check("flags", {o_enc_64b66b, o_single_channel, o_scramble_enable}, {enc, single, scr});
    end
    if (!enc && !bad) begin
      for (int b = 0; b < 2; b++)
        for (int ln = 0; ln < l; ln++)
          for (int ix = 0; ix < 14; ix++)
            exp_q.push_back({1'(b), 3'(ln), 4'(ix), octet(ix, did + 8'(b), k, lm, 8'(ln), scr)});
    end
    stall = code[0];
    i_link_enable = 1'b1;
    wait_cycles(1);
    check("busy", o_ilas_busy, 1'(!enc && !bad));
    guard = 0;
    while ((exp_q.size() != 0 || (!enc && !bad && o_ilas_done !== 1'b1)) && guard < 3000) begin
      wait_cycles(1);
      guard++;
    end
    if (guard == 3000) begin
      check("timeout", 1, 0);
      close_out();
    end
    wait_cycles(30);
    check("busy_idle", o_ilas_busy, 0);
    check("done", o_ilas_done, 1'(!enc && !bad));
    i_link_enable = 1'b0;
    wait_cycles(3);
    $display("Mode %0d done", code);
  endtask

  initial begin
    i_rst_n = 1'b0;
    i_link_mode_select = 7'h05;
    i_frames_per_multiframe_minus_one = 8'h1F;
    i_device_id = 8'h00;
    i_scrambler_enable = 1'b0;
    i_link_enable = 1'b0;
    stall = 1'b0;
    void'($urandom(40));
    wait_cycles(12);
    check("reset", {o_word_valid, o_lane_enable, o_mode_invalid}, 0);
    i_rst_n = 1'b1;
    run_mode(7'h05, 4, 0, 1, 0);
    run_mode(7'h06, 8, 0, 1, 0);
    run_mode(7'h07, 4, 0, 0, 0);
    run_mode(7'h08, 8, 0, 0, 0);
    run_mode(7'h22, 2, 1, 1, 0);
    run_mode(7'h23, 2, 1, 0, 0);
    run_mode(7'h2C, 4, 1, 1, 0);
    run_mode(7'h2D, 4, 1, 0, 0);
    run_mode(7'h32, 8, 1, 1, 0);
    run_mode(7'h33, 8, 1, 0, 0);
    run_mode(7'h09, 0, 0, 0, 1);
    run_mode(7'h04, 0, 0, 0, 1);
    close_out();
  end
endmodule
